// *** rtl/video_out_port_signal_select.sv ***
// Output signal selection, polarity, range limit and byte swap for the video port.
// Operation
// - Horizontal select gives gate, extended gate, gate-edge pulse or extended-edge pulse.
// - Extended gate frames scaler lines, passes input horizontal reference outside window.
// - Vertical select gives gate, input reference, gate pulse or input-reference pulse.
// - General output one uses three-bit selector over eight sources.
// - General output zero has its own selector with identical encoding.
// - Field ID and task flag follow their definition bits.
// - Sliced-data flag is high exactly while sliced data words are delivered.
// - Constant source is zero; only inversion sets the pin level.
// - FIFO flags are almost filled, overflow, almost full, almost empty.
// - Each of five outputs has a polarity bit; one inverts.
// - Range bit clips video to 1..254 or 8..247.
// - Swap field reorders the four bytes of each output word.
// - Qualifier pin carries data valid or gated port clock.
// - Almost full threshold is 16, 24, 28 or 32 words.
// - Almost empty threshold is under 16, 8, 4 words, or zero.
`timescale 1ns/1ns
`default_nettype none
`include "vop_defines.svh"

module video_out_port_signal_select (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output var  logic [7:0]  reg_rdata,
  input  wire logic        port_clk,
  input  wire logic        out_field_id_def,
  input  wire logic        task_flag_level_def,
  input  wire logic        qualifier_clock_gate_sel,
  input  wire logic        scaler_window,
  input  wire logic        h_gate,
  input  wire logic        h_ref_in,
  input  wire logic        v_gate,
  input  wire logic        v_ref_in,
  input  wire logic        field_id_scaler,
  input  wire logic        field_id_slicer,
  input  wire logic        task_flag_in,
  input  wire logic        sliced_active,
  input  wire logic [5:0]  fifo_level,
  input  wire logic        fifo_overflow,
  input  wire logic        data_valid,
  input  wire logic        data_is_timing_ref,
  input  wire logic [31:0] data_word,
  output var  logic        port_data_qualifier,
  output var  logic        horiz_ref_out,
  output var  logic        vert_ref_out,
  output var  logic        gp_out_one,
  output var  logic        gp_out_zero,
  output var  logic [31:0] port_data
);

  vop_pkg::st_t q;
  vop_pkg::st_t d;
  logic         pclk_level;
  logic         port_rise;
  logic [2:0]   gp1_sel;
  logic [2:0]   gp0_sel;
  logic [1:0]   swap;
  logic         range_lim;
  logic         almost_full_flag;
  logic         almost_empty_flag;
  logic         almost_filled_flag;
  logic         h_ext;
  logic         field_src;
  logic         task_src;

  // ========================================================================
  // The port clock is a pin, so it is synchronised before its edge is used.
  vop_edge_sync u_pclk (
    .mclk  (mclk),
    .rst_b (rst_b),
    .pin   (port_clk),
    .level (pclk_level),
    .rise  (port_rise)
  );

  // ========================================================================
  // Selector fields gathered from the registers.
  assign gp1_sel   = {q.r86[`VOP_GP1_SEL_HI], q.r84[`VOP_GP1_SEL_LO +: 2]};
  assign gp0_sel   = {q.r86[`VOP_GP0_SEL_HI], q.r84[`VOP_GP0_SEL_LO +: 2]};
  assign swap      = q.r85[`VOP_SWAP_LO +: 2];
  assign range_lim = q.r85[`VOP_RANGE_LIM];

  // FIFO flags: almost full and almost empty from the programmed levels, almost filled from the fixed level of 8 words.
  always_comb begin
    case (q.r86[`VOP_AF_LVL_LO +: 2])
      2'b00:   almost_full_flag = fifo_level >= `VOP_AF_16;
      2'b01:   almost_full_flag = fifo_level >= `VOP_AF_24;
      2'b10:   almost_full_flag = fifo_level >= `VOP_AF_28;
      default: almost_full_flag = fifo_level >= `VOP_AF_32;
    endcase
    case (q.r86[`VOP_AE_LVL_LO +: 2])
      2'b00:   almost_empty_flag = fifo_level < `VOP_AE_16;
      2'b01:   almost_empty_flag = fifo_level < `VOP_AE_8;
      2'b10:   almost_empty_flag = fifo_level < `VOP_AE_4;
      default: almost_empty_flag = fifo_level == `VOP_AE_0;
    endcase
    almost_filled_flag = fifo_level >= `VOP_FILLED_LVL;
  end

  // Extended gate and the field and task sources.
  assign h_ext     = scaler_window ? h_gate : h_ref_in;
  assign field_src = out_field_id_def ? field_id_slicer : field_id_scaler;
  assign task_src  = task_flag_level_def ? ~task_flag_in : task_flag_in;

  // ========================================================================
  // Eight-way source mux shared by both general-purpose outputs.
  function automatic logic gp_mux(input logic [2:0] sel, input logic fid,
                                  input logic tsk, input logic slc,
                                  input logic afl, input logic ovf,
                                  input logic afu, input logic aem);
    case (sel)
      3'b000:  gp_mux = fid;
      3'b001:  gp_mux = tsk;
      3'b010:  gp_mux = slc;
      3'b011:  gp_mux = 1'b0;
      3'b100:  gp_mux = afl;
      3'b101:  gp_mux = ovf;
      3'b110:  gp_mux = afu;
      default: gp_mux = aem;
    endcase
  endfunction

  // Clip one pixel byte; timing reference bytes are never clipped.
  function automatic logic [7:0] clip(input logic [7:0] b, input logic lim);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = lim ? `VOP_NARROW_LO : `VOP_WIDE_LO;
    hi = lim ? `VOP_NARROW_HI : `VOP_WIDE_HI;
    if (b < lo) begin
      clip = lo;
    end else if (b > hi) begin
      clip = hi;
    end else begin
      clip = b;
    end
  endfunction

  // ========================================================================
  // Next state: register writes, read data and the port-clock outputs.
  always_comb begin
    d = q;
    if (reg_wr) begin
      case (reg_addr)
        `VOP_ADDR_SYNC_GP:  d.r84 = reg_wdata;
        `VOP_ADDR_POL_SWAP: d.r85 = reg_wdata;
        `VOP_ADDR_FIFO_ARB: d.r86 = reg_wdata;
        default:            d.r84 = q.r84;
      endcase
    end
    // Reads return the stored value, unmapped addresses read as zero.
    case (reg_addr)
      `VOP_ADDR_SYNC_GP:  d.rdata = q.r84;
      `VOP_ADDR_POL_SWAP: d.rdata = q.r85;
      `VOP_ADDR_FIFO_ARB: d.rdata = q.r86;
      default:            d.rdata = `VOP_UNMAPPED_READ;
    endcase
    // Reference, general and data outputs move only on a port clock edge so they stay aligned with data.
    if (port_rise) begin
      d.h_prev  = h_gate;
      d.hx_prev = h_ext;
      d.v_prev  = v_gate;
      d.vr_prev = v_ref_in;
      case (q.r84[`VOP_HREF_SEL_LO +: 2])
        2'b00:   d.href = h_gate;
        2'b01:   d.href = h_ext;
        2'b10:   d.href = h_gate & ~q.h_prev;
        default: d.href = h_ext & ~q.hx_prev;
      endcase
      case (q.r84[`VOP_VREF_SEL_LO +: 2])
        2'b00:   d.vref = v_gate;
        2'b01:   d.vref = v_ref_in;
        2'b10:   d.vref = v_gate & ~q.v_prev;
        default: d.vref = v_ref_in & ~q.vr_prev;
      endcase
      d.href = d.href ^ q.r85[`VOP_HREF_INV];
      d.vref = d.vref ^ q.r85[`VOP_VREF_INV];
      d.gp1  = gp_mux(gp1_sel, field_src, task_src, sliced_active, almost_filled_flag,
                      fifo_overflow, almost_full_flag, almost_empty_flag)
               ^ q.r85[`VOP_GP1_INV];
      d.gp0  = gp_mux(gp0_sel, field_src, task_src, sliced_active, almost_filled_flag,
                      fifo_overflow, almost_full_flag, almost_empty_flag)
               ^ q.r85[`VOP_GP0_INV];
      // Lane i takes source byte i xor swap, for timing and pixel bytes alike.
      for (int i = 0; i < 4; i++) begin
        d.data[8*i +: 8] = data_is_timing_ref ? data_word[8*(i ^ int'(swap)) +: 8]
                         : clip(data_word[8*(i ^ int'(swap)) +: 8], range_lim);
      end
    end
    // The gated clock form follows the port clock level, so it is not held.
    if (qualifier_clock_gate_sel) begin
      d.qual = (data_valid & pclk_level) ^ q.r85[`VOP_QUAL_INV];
    end else if (port_rise) begin
      d.qual = data_valid ^ q.r85[`VOP_QUAL_INV];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Every output is a field of the registered state.
  assign reg_rdata           = q.rdata;
  assign port_data_qualifier = q.qual;
  assign horiz_ref_out       = q.href;
  assign vert_ref_out        = q.vref;
  assign gp_out_one          = q.gp1;
  assign gp_out_zero         = q.gp0;
  assign port_data           = q.data;

  // ========================================================================
  // Checks on the selected outputs.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_h_rise;
    port_rise && h_gate && !q.h_prev;
  endsequence

  property p_h_pulse;
    s_h_rise ##0 (q.r84[1:0] == 2'b10) |=> horiz_ref_out == !$past(q.r85[1]);
  endproperty
  a_h_pulse: assert property (p_h_pulse) else $error("pulse missing at gate edge");

  property p_h_ext;
    port_rise && q.r84[1:0] == 2'b01 && !scaler_window
      |=> horiz_ref_out == ($past(h_ref_in) ^ $past(q.r85[1]));
  endproperty
  a_h_ext: assert property (p_h_ext) else $error("extended gate wrong outside window");

  property p_v_ref;
    port_rise && q.r84[3:2] == 2'b01 |=> vert_ref_out == ($past(v_ref_in) ^ $past(q.r85[2]));
  endproperty
  a_v_ref: assert property (p_v_ref) else $error("vertical reference not passed");

  property p_gp1_ovf;
    port_rise && gp1_sel == 3'b101 |=> gp_out_one == ($past(fifo_overflow) ^ $past(q.r85[3]));
  endproperty
  a_gp1_ovf: assert property (p_gp1_ovf) else $error("overflow flag not on output one");

  // The task source honours its level definition bit before the pin inversion.
  property p_gp1_task;
    port_rise && gp1_sel == 3'b001
      |=> gp_out_one == ($past(task_flag_in ^ task_flag_level_def) ^ $past(q.r85[3]));
  endproperty
  a_gp1_task: assert property (p_gp1_task) else $error("task flag not on output one");

  property p_gp1_filled;
    port_rise && gp1_sel == 3'b100
      |=> gp_out_one == (($past(fifo_level) >= 6'h08) ^ $past(q.r85[3]));
  endproperty
  a_gp1_filled: assert property (p_gp1_filled) else $error("almost filled flag wrong");

  property p_gp0_const;
    port_rise && gp0_sel == 3'b011 |=> gp_out_zero == $past(q.r85[4]);
  endproperty
  a_gp0_const: assert property (p_gp0_const) else $error("constant source not zero");

  property p_gp0_slice;
    port_rise && gp0_sel == 3'b010 && !q.r85[4] |=> gp_out_zero == $past(sliced_active);
  endproperty
  a_gp0_slice: assert property (p_gp0_slice) else $error("sliced flag mismatch");

  property p_ae_zero;
    port_rise && gp1_sel == 3'b111 && q.r86[1:0] == 2'b11 && fifo_level == 6'h01
      |=> gp_out_one == $past(q.r85[3]);
  endproperty
  a_ae_zero: assert property (p_ae_zero) else $error("almost empty set at one word");

  property p_af_28;
    port_rise && gp0_sel == 3'b110 && q.r86[3:2] == 2'b10 && fifo_level == 6'h1c
      |=> gp_out_zero == !$past(q.r85[4]);
  endproperty
  a_af_28: assert property (p_af_28) else $error("almost full not set at 28 words");

  property p_clip;
    port_rise && !data_is_timing_ref && range_lim && data_word[8*swap +: 8] < 8'h08
      |=> port_data[7:0] == 8'h08;
  endproperty
  a_clip: assert property (p_clip) else $error("narrow range floor not applied");

  property p_swap;
    port_rise && data_is_timing_ref && swap == 2'b11
      |=> port_data[7:0] == $past(data_word[31:24]) && port_data[31:24] == $past(data_word[7:0]);
  endproperty
  a_swap: assert property (p_swap) else $error("full byte reverse wrong");

  property p_gate_clk;
    qualifier_clock_gate_sel && data_valid && !pclk_level
      |=> port_data_qualifier == $past(q.r85[0]);
  endproperty
  a_gate_clk: assert property (p_gate_clk) else $error("gated clock active while clock low");

  property p_hold;
    !port_rise |=> $stable(horiz_ref_out) && $stable(gp_out_one) && $stable(port_data);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved between port edges");

endmodule // video_out_port_signal_select

`default_nettype wire

// *** rtl/vop_defines.svh ***
// Constants for the video output port signal select block.
`ifndef VOP_DEFINES_SVH
`define VOP_DEFINES_SVH

// ==========================================================================
// Register offsets
`define VOP_ADDR_SYNC_GP   8'h84
`define VOP_ADDR_POL_SWAP  8'h85
`define VOP_ADDR_FIFO_ARB  8'h86
`define VOP_RESET_VAL      8'h00
`define VOP_UNMAPPED_READ  8'h00

// ==========================================================================
// Field positions in the sync and general-purpose select register
`define VOP_HREF_SEL_LO    0
`define VOP_VREF_SEL_LO    2
`define VOP_GP1_SEL_LO     4
`define VOP_GP0_SEL_LO     6
// Field positions in the polarity, range and swap register
`define VOP_QUAL_INV       0
`define VOP_HREF_INV       1
`define VOP_VREF_INV       2
`define VOP_GP1_INV        3
`define VOP_GP0_INV        4
`define VOP_RANGE_LIM      5
`define VOP_SWAP_LO        6
// Field positions in the FIFO flag register
`define VOP_AE_LVL_LO      0
`define VOP_AF_LVL_LO      2
`define VOP_GP1_SEL_HI     4
`define VOP_GP0_SEL_HI     5

// ==========================================================================
// Video value limits
`define VOP_WIDE_LO        8'h01
`define VOP_WIDE_HI        8'hfe
`define VOP_NARROW_LO      8'h08
`define VOP_NARROW_HI      8'hf7

// ==========================================================================
// FIFO levels in words
`define VOP_AF_16          6'h10
`define VOP_AF_24          6'h18
`define VOP_AF_28          6'h1c
`define VOP_AF_32          6'h20
`define VOP_AE_16          6'h10
`define VOP_AE_8           6'h08
`define VOP_AE_4           6'h04
`define VOP_AE_0           6'h00
`define VOP_FILLED_LVL     6'h08

`endif

// *** rtl/vop_edge_sync.sv ***
// Two-flop synchroniser with rising edge finder for a pin input.
`timescale 1ns/1ns
`default_nettype none

module vop_edge_sync (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic pin,
  output var  logic level,
  output var  logic rise
);

  vop_pkg::sync_st_t q;
  vop_pkg::sync_st_t d;

  // ========================================================================
  // The first flop feeds only the second; the edge finder looks further on.
  always_comb begin
    d    = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Level and edge seen after synchronisation.
  assign level = q.s2;
  assign rise  = q.s2 & ~q.s3;

endmodule // vop_edge_sync

`default_nettype wire

// *** rtl/vop_pkg.sv ***
// Types shared by the video output port signal select block.
package vop_pkg;

  // ========================================================================
  // State of the pin edge finder.
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_st_t;

  // ========================================================================
  // State of the signal select block.
  typedef struct packed {
    logic [7:0]  r84;
    logic [7:0]  r85;
    logic [7:0]  r86;
    logic [7:0]  rdata;
    logic        h_prev;
    logic        hx_prev;
    logic        v_prev;
    logic        vr_prev;
    logic        qual;
    logic        href;
    logic        vref;
    logic        gp1;
    logic        gp0;
    logic [31:0] data;
  } st_t;

endpackage

// *** sim/video_out_port_signal_select_tb_top.sv ***
// Testbench for the video output port signal select block.
`timescale 1ns/1ns
`default_nettype none

module video_out_port_signal_select_tb_top;
  logic        mclk, rst_b, reg_wr, port_clk, run, q, h, v, g1, g0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, r84, r85, r86;
  logic        fdef, tdef, gsel, win, hg, hr, vg, vr, fsc, fsl, tin, sl, ovf, dv, tr;
  logic        ph, phx, pv, pvr;
  logic [5:0]  lvl;
  logic [31:0] dw, pd;
  logic [36:0] cap;
  int          miscompares, checked;
  logic [5:0]  af_t [4] = '{6'h10, 6'h18, 6'h1c, 6'h20};
  logic [5:0]  ae_t [4] = '{6'h10, 6'h08, 6'h04, 6'h00};
  logic [5:0]  lvls [14] = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h07, 6'h08, 6'h0f, 6'h10,
                             6'h17, 6'h18, 6'h1b, 6'h1c, 6'h1f, 6'h20};
  logic [4:0]  pat [8] = '{5'h01, 5'h0b, 5'h1f, 5'h05, 5'h00, 5'h15, 5'h1b, 5'h0f};

  // ==========================================================================
  // Design and host model
  video_out_port_signal_select video_out_port_signal_select_i (
    .mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port_clk(port_clk),
    .out_field_id_def(fdef), .task_flag_level_def(tdef),
    .qualifier_clock_gate_sel(gsel), .scaler_window(win), .h_gate(hg),
    .h_ref_in(hr), .v_gate(vg), .v_ref_in(vr), .field_id_scaler(fsc),
    .field_id_slicer(fsl), .task_flag_in(tin), .sliced_active(sl),
    .fifo_level(lvl), .fifo_overflow(ovf), .data_valid(dv),
    .data_is_timing_ref(tr), .data_word(dw), .port_data_qualifier(q),
    .horiz_ref_out(h), .vert_ref_out(v), .gp_out_one(g1), .gp_out_zero(g0),
    .port_data(pd)
  );
  vop_host_capture vop_host_capture_i (
    .run(run), .port_clk(port_clk), .qual(q), .href(h), .vref(v),
    .gp1(g1), .gp0(g0), .data(pd), .cap(cap)
  );

  // ==========================================================================
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // The tests need about 30 us; three times that means a hang.
  initial begin
    #100000;
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ==========================================================================
  // Reference model of the port pins
  // Sources of the general outputs, following the eight-code encoding.
  function automatic logic gp_src(input logic [2:0] c);
    case (c)
      3'h0: return fdef ? fsl : fsc;
      3'h1: return tin ^ tdef;
      3'h2: return sl;
      3'h3: return 1'b0;
      3'h4: return lvl >= 6'h08;
      3'h5: return ovf;
      3'h6: return lvl >= af_t[r86[3:2]];
      default: return (r86[1:0] == 2'h3) ? (lvl == 6'h00) : (lvl < ae_t[r86[1:0]]);
    endcase
  endfunction

  // Whole port word as it should stand after one port clock edge.
  function automatic logic [36:0] expect_out();
    logic       hx, hh, vv;
    logic [7:0] b, lo, hi;
    logic [31:0] d;
    hx = win ? hg : hr;
    case (r84[1:0])
      2'h0: hh = hg;
      2'h1: hh = hx;
      2'h2: hh = hg & ~ph;
      default: hh = hx & ~phx;
    endcase
    case (r84[3:2])
      2'h0: vv = vg;
      2'h1: vv = vr;
      2'h2: vv = vg & ~pv;
      default: vv = vr & ~pvr;
    endcase
    lo = r85[5] ? 8'h08 : 8'h01;
    hi = r85[5] ? 8'hf7 : 8'hfe;
    for (int i = 0; i < 4; i++) begin
      b = dw[8 * (i ^ r85[7:6]) +: 8];
      if (!tr) b = (b < lo) ? lo : ((b > hi) ? hi : b);
      d[8 * i +: 8] = b;
    end
    return {(dv & ~gsel) ^ r85[0], hh ^ r85[1], vv ^ r85[2],
            gp_src({r86[4], r84[5:4]}) ^ r85[3], gp_src({r86[5], r84[7:6]}) ^ r85[4], d};
  endfunction

  // ==========================================================================
  // Access tasks
  task automatic compare(input logic [36:0] seen, input logic [36:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    @(negedge mclk);
    @(negedge mclk);
    compare({29'h0, reg_rdata}, {29'h0, e});
  endtask

  // Inputs change only in the quiet middle of a port period.
  task automatic window();
    @(posedge port_clk);
    #45;
    @(negedge mclk);
  endtask

  // Back-to-back writes, the first to an unmapped place that must be ignored.
  task automatic setregs(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    window();
    reg_wr = 1'b1;
    reg_addr = 8'h87;
    reg_wdata = 8'hff;
    @(negedge mclk);
    reg_addr = 8'h84;
    reg_wdata = a;
    @(negedge mclk);
    reg_addr = 8'h85;
    reg_wdata = b;
    @(negedge mclk);
    reg_addr = 8'h86;
    reg_wdata = c;
    @(negedge mclk);
    reg_wr = 1'b0;
    {r84, r85, r86} = {a, b, c};
  endtask

  // First rise samples the inputs; the second captures the result.
  task automatic check();
    logic [36:0] e;
    e = expect_out();
    @(posedge port_clk);
    @(posedge port_clk);
    #1;
    compare({cap[36:32], dv ? cap[31:0] : 32'h0}, {e[36:32], dv ? e[31:0] : 32'h0});
    {ph, phx, pv, pvr} = {hg, win ? hg : hr, vg, vr};
  endtask

  task automatic end_of_test();
    $display("counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    {rst_b, reg_wr, reg_addr, reg_wdata, run, fdef, tdef, gsel, win, hg, hr} = '0;
    {vg, vr, fsc, fsl, tin, sl, lvl, ovf, dv, tr, dw, r84, r85, r86} = '0;
    {ph, phx, pv, pvr} = 4'h0;
    miscompares = 0;
    checked = 0;
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    run = 1'b1;
    rd(8'h84, 8'h00);
    rd(8'h85, 8'h00);
    rd(8'h86, 8'h00);
    setregs(8'h5a, 8'ha5, 8'hc3);
    rd(8'h84, 8'h5a);
    rd(8'h85, 8'ha5);
    rd(8'h86, 8'hc3);
    rd(8'h87, 8'h00);
    $display("test registers done");
    // Two input sets are applied to every source code on both general outputs.
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 8; c++) begin
        setregs({c[1:0], c[1:0], 4'h0}, s ? 8'h18 : 8'h00,
                {2'h0, c[2], c[2], s ? 4'h1 : 4'hf});
        window();
        {fdef, tdef, fsc, fsl, tin, sl, ovf} = s ? 7'h6c : 7'h2b;
        lvl = s ? 6'h04 : 6'h20;
        check();
      end
    end
    $display("test general sources done");
    // Every flag level code at both sides of its threshold.
    for (int k = 0; k < 4; k++) begin
      setregs(8'hb0, 8'h00, {4'h3, k[1:0], k[1:0]});
      for (int j = 0; j < 14; j++) begin
        window();
        lvl = lvls[j];
        check();
      end
    end
    $display("test flag levels done");
    // Each reference mode, with swap, range and inversion varied alongside.
    for (int m = 0; m < 4; m++) begin
      setregs({4'h0, m[1:0], m[1:0]}, {m[1:0], m[1], m[0] ? 5'h1f : 5'h00}, 8'h00);
      for (int j = 0; j < 8; j++) begin
        window();
        {win, hg, hr, vg, vr} = pat[j];
        {dv, gsel, tr} = {pat[j][0] | j[0], m[0] & j[1], j == 3};
        dw = j[0] ? 32'h00ff07f8 : 32'h01fe0880;
        check();
      end
    end
    $display("test references and data done");
    end_of_test();
  end
endmodule // video_out_port_signal_select_tb_top

`default_nettype wire

// *** sim/vop_host_capture.sv ***
// Host back-end model: makes the port clock and latches the port pins.
`timescale 1ns/1ns
`default_nettype none

module vop_host_capture (
  input  wire logic        run,
  output var  logic        port_clk,
  input  wire logic        qual,
  input  wire logic        href,
  input  wire logic        vref,
  input  wire logic        gp1,
  input  wire logic        gp0,
  input  wire logic [31:0] data,
  output var  logic [36:0] cap
);
  // ==========================================================================
  // Port clock
  // Period 80 ns, phase unrelated to mclk; it stands low while run is low.
  initial begin
    port_clk = 1'b0;
    #3;
    forever begin
      #40 port_clk = run ? ~port_clk : 1'b0;
    end
  end

  // ==========================================================================
  // Capture
  // Pins are taken on the rise, before the device moves them a few mclk later.
  always @(posedge port_clk) begin
    cap <= {qual, href, vref, gp1, gp0, data};
  end
endmodule // vop_host_capture

`default_nettype wire
